// file: rtl/sbau_pkg.sv
// shared widths, field positions, latencies and carrier types for the byte arithmetic unit
// assumes the issue pipeline presents one operation per cycle and takes results per latency
package sbau_pkg;

	// lane geometry
	localparam int SBAU_BYTE_W = 8; // one lane
	localparam int SBAU_LANES = 4; // lanes per word
	localparam int SBAU_WORD_W = 32; // general register width
	localparam int SBAU_BR_W = 4; // branch register width, one bit per lane
	localparam int SBAU_SUM2_W = 9; // two-way average sum
	localparam int SBAU_SUM4_W = 10; // four-way average sum
	localparam int SBAU_PROD_W = 16; // unsigned by signed byte product
	localparam int SBAU_PAIR_W = 17; // sum of two products
	localparam int SBAU_MAC_W = 18; // sum of four products
	localparam int SBAU_SAD_W = 10; // sum of four absolute differences

	// destination bit positions of the two four-way results
	localparam int SBAU_AVG4_LO_POS = 0; // lower half result
	localparam int SBAU_AVG4_HI_POS = 16; // upper half result

	// fixed latencies in cycles from issue
	localparam int SBAU_LAT_SHORT = 1; // lane ops and compares
	localparam int SBAU_LAT_MID = 2; // summed difference and four-way average
	localparam int SBAU_LAT_LONG = 3; // multiply add across

	// four-way rounding codes taken from the two low branch bits
	localparam logic [1:0] SBAU_ROUND_TOWARD_ZERO = 2'h0;
	localparam logic [1:0] SBAU_ROUND_NEAREST_TIES_DOWN = 2'h1;
	localparam logic [1:0] SBAU_ROUND_NEAREST_TIES_UP = 2'h2;
	localparam logic [1:0] SBAU_ROUND_TOWARD_POSITIVE = 2'h3;

	// operations accepted by the unit
	typedef enum logic [3:0] {
		SBAU_NOP,
		SBAU_LANE_ABS_DIFF,
		SBAU_LANE_ABS_DIFF_ALIAS,
		SBAU_SUMMED_ABS_DIFF,
		SBAU_TWO_WAY_AVERAGE,
		SBAU_FOUR_WAY_AVERAGE,
		SBAU_BYTE_EQUAL_COMPARE,
		SBAU_BYTE_UNSIGNED_GREATER_COMPARE,
		SBAU_MIXED_SIGN_MULTIPLY_ADD_ACROSS
	} sbau_op_t;

	// one issued operation
	typedef struct packed {
		logic valid; // operation present this cycle
		sbau_op_t op; // what to do
		logic to_br; // compare writes a branch register
		logic [SBAU_BR_W-1:0] branch_condition_operand; // rounding or unused
		logic [SBAU_WORD_W-1:0] src1; // first source
		logic [SBAU_WORD_W-1:0] src2; // second source
	} sbau_issue_t;

	// one result port of a latency group
	typedef struct packed {
		logic valid; // result present this cycle
		logic to_br; // take br, not data
		logic [SBAU_BR_W-1:0] br; // branch register result
		logic [SBAU_WORD_W-1:0] data; // general register result
	} sbau_res_t;

	// reset value of every result port
	localparam sbau_res_t SBAU_RES_RESET = '0;

endpackage : sbau_pkg

// file: rtl/sbau_lane.sv
// one byte lane: absolute difference, two-way average, compares and mixed-sign product
// assumes the caller registers the outputs; purely combinational
`timescale 1ns/1ps
module sbau_lane import sbau_pkg::*; (
	input wire logic [SBAU_BYTE_W-1:0] a,
	input wire logic [SBAU_BYTE_W-1:0] b,
	input wire logic rnd_up,
	output logic [SBAU_BYTE_W-1:0] abs_diff,
	output logic [SBAU_BYTE_W-1:0] average,
	output logic equal,
	output logic greater,
	output logic signed [SBAU_PROD_W-1:0] product
);

	logic [SBAU_SUM2_W-1:0] sum2; // a plus b plus rounding
	logic signed [SBAU_BYTE_W:0] a_u; // a as non-negative signed
	logic signed [SBAU_BYTE_W-1:0] b_s; // b as signed

	// both bytes unsigned except b in the product
	assign greater = a > b;
	assign equal = a == b;
	assign abs_diff = greater ? a - b : b - a;

	// sum before halving keeps the carry
	assign sum2 = {1'b0, a} + {1'b0, b} + {{(SBAU_SUM2_W-1){1'b0}}, rnd_up};
	assign average = sum2[SBAU_SUM2_W-1:1];

	// unsigned by signed product fits 16 bits exactly
	assign a_u = {1'b0, a};
	assign b_s = b;
	// both factors widened first so the product keeps all sixteen bits
	assign product = SBAU_PROD_W'(a_u) * SBAU_PROD_W'(b_s);

endmodule : sbau_lane

// file: rtl/sbau_round4.sv
// four-byte average with a two-bit rounding bias
// assumes the caller registers the result; purely combinational
`timescale 1ns/1ps
module sbau_round4 import sbau_pkg::*; (
	input wire logic [SBAU_BYTE_W-1:0] p0,
	input wire logic [SBAU_BYTE_W-1:0] p1,
	input wire logic [SBAU_BYTE_W-1:0] p2,
	input wire logic [SBAU_BYTE_W-1:0] p3,
	input wire logic [1:0] mode,
	output logic [SBAU_BYTE_W-1:0] average
);

	logic [SBAU_SUM4_W-1:0] sum4; // worst case 1023, no overflow

	// bias 0..3 picks zero, ties down, ties up or positive
	assign sum4 = SBAU_SUM4_W'(p0) + SBAU_SUM4_W'(p1) + SBAU_SUM4_W'(p2) + SBAU_SUM4_W'(p3)
		+ SBAU_SUM4_W'(mode);
	assign average = sum4[SBAU_SUM4_W-1:2];

endmodule : sbau_round4

// file: rtl/sbau_top.sv
// packed byte arithmetic unit with three result ports, one per fixed latency
// assumes the issue pipeline takes each port's result the cycle it is valid
`timescale 1ns/1ps
module sbau_top import sbau_pkg::*; (
	input wire logic CLK,
	input wire logic RESETN,
	input wire sbau_issue_t ISSUE,
	output sbau_res_t RES_L1,
	output sbau_res_t RES_L2,
	output sbau_res_t RES_L3
);

	// operation decode
	wire logic is_abs; // lane difference, either name
	wire logic is_sad; // summed difference
	wire logic is_avg2; // two-way average
	wire logic is_avg4; // four-way average
	wire logic is_eq; // equality compare
	wire logic is_gt; // unsigned greater compare
	wire logic is_mac; // multiply add across
	wire logic is_cmp; // either compare

	assign is_abs = ISSUE.valid && (ISSUE.op == SBAU_LANE_ABS_DIFF || ISSUE.op == SBAU_LANE_ABS_DIFF_ALIAS);
	assign is_sad = ISSUE.valid && ISSUE.op == SBAU_SUMMED_ABS_DIFF;
	assign is_avg2 = ISSUE.valid && ISSUE.op == SBAU_TWO_WAY_AVERAGE;
	assign is_avg4 = ISSUE.valid && ISSUE.op == SBAU_FOUR_WAY_AVERAGE;
	assign is_eq = ISSUE.valid && ISSUE.op == SBAU_BYTE_EQUAL_COMPARE;
	assign is_gt = ISSUE.valid && ISSUE.op == SBAU_BYTE_UNSIGNED_GREATER_COMPARE;
	assign is_mac = ISSUE.valid && ISSUE.op == SBAU_MIXED_SIGN_MULTIPLY_ADD_ACROSS;
	assign is_cmp = is_eq || is_gt;

	// shared rounding controls, one value for the whole word
	wire logic rnd2_up; // two-way bias bit
	wire logic [1:0] rnd4_mode; // four-way bias
	assign rnd2_up = |ISSUE.branch_condition_operand;
	assign rnd4_mode = ISSUE.branch_condition_operand[1:0];

	// per-lane results
	logic [SBAU_LANES-1:0][SBAU_BYTE_W-1:0] absd; // absolute differences
	logic [SBAU_LANES-1:0][SBAU_BYTE_W-1:0] avg2; // two-way averages
	logic [SBAU_LANES-1:0] eq; // equal flags
	logic [SBAU_LANES-1:0] gt; // greater flags
	logic [SBAU_LANES-1:0][SBAU_PROD_W-1:0] prod; // signed products
	wire logic [SBAU_LANES-1:0] cmp_bits; // chosen compare flags
	logic [SBAU_WORD_W-1:0] cmp_gr; // compare flags laid out one per byte

	assign cmp_bits = is_eq ? eq : gt;

	// one lane slice per byte, same bias in each
	genvar gi;
	for (gi = 0; gi < SBAU_LANES; gi++) begin : g_lane
		logic signed [SBAU_PROD_W-1:0] lane_prod; // lane product
		sbau_lane u_lane (
			.a(ISSUE.src1[gi*SBAU_BYTE_W +: SBAU_BYTE_W]),
			.b(ISSUE.src2[gi*SBAU_BYTE_W +: SBAU_BYTE_W]),
			.rnd_up(rnd2_up),
			.abs_diff(absd[gi]),
			.average(avg2[gi]),
			.equal(eq[gi]),
			.greater(gt[gi]),
			.product(lane_prod)
		);
		assign prod[gi] = lane_prod;
		// truth in the byte LSB, upper seven bits cleared
		assign cmp_gr[gi*SBAU_BYTE_W +: SBAU_BYTE_W] = {7'h00, cmp_bits[gi]};
	end

	// short latency result
	sbau_res_t l1_nxt; // next short result
	sbau_res_t l1_r; // short result register
	wire logic [SBAU_WORD_W-1:0] l1_data; // general register word
	wire logic l1_to_br; // compare into branch register

	assign l1_to_br = is_cmp && ISSUE.to_br;
	assign l1_data = is_abs ? absd :
		is_avg2 ? avg2 :
		(is_cmp && !ISSUE.to_br) ? cmp_gr : '0;
	assign l1_nxt.valid = is_abs || is_avg2 || is_cmp;
	assign l1_nxt.to_br = l1_to_br;
	assign l1_nxt.br = l1_to_br ? cmp_bits : '0;
	assign l1_nxt.data = l1_data;

	// short stage register, one cycle from issue
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			l1_r <= SBAU_RES_RESET;
		end else begin
			l1_r <= l1_nxt;
		end
	end
	assign RES_L1 = l1_r;

	// four-way averages over the lower and upper halves
	logic [SBAU_BYTE_W-1:0] avg4_lo; // lower half average
	logic [SBAU_BYTE_W-1:0] avg4_hi; // upper half average

	sbau_round4 u_avg4_lo (
		.p0(ISSUE.src1[7:0]),
		.p1(ISSUE.src1[15:8]),
		.p2(ISSUE.src2[7:0]),
		.p3(ISSUE.src2[15:8]),
		.mode(rnd4_mode),
		.average(avg4_lo)
	);

	sbau_round4 u_avg4_hi (
		.p0(ISSUE.src1[23:16]),
		.p1(ISSUE.src1[31:24]),
		.p2(ISSUE.src2[23:16]),
		.p3(ISSUE.src2[31:24]),
		.mode(rnd4_mode),
		.average(avg4_hi)
	);

	// middle latency first stage
	logic s1_sad_r; // summed difference in flight
	logic s1_avg4_r; // four-way average in flight
	logic [SBAU_LANES-1:0][SBAU_BYTE_W-1:0] s1_absd_r; // differences awaiting sum
	logic [SBAU_BYTE_W-1:0] s1_lo_r; // lower average
	logic [SBAU_BYTE_W-1:0] s1_hi_r; // upper average

	// capture lane differences and four-way averages of the two-cycle operations
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			s1_sad_r <= 1'b0;
			s1_avg4_r <= 1'b0;
			s1_absd_r <= '0;
			s1_lo_r <= '0;
			s1_hi_r <= '0;
		end else begin
			s1_sad_r <= is_sad;
			s1_avg4_r <= is_avg4;
			s1_absd_r <= absd;
			s1_lo_r <= avg4_lo;
			s1_hi_r <= avg4_hi;
		end
	end

	// add the four differences in the second cycle
	wire logic [SBAU_SAD_W-1:0] sad_sum; // at most 1020
	assign sad_sum = SBAU_SAD_W'(s1_absd_r[0]) + SBAU_SAD_W'(s1_absd_r[1])
		+ SBAU_SAD_W'(s1_absd_r[2]) + SBAU_SAD_W'(s1_absd_r[3]);

	sbau_res_t l2_nxt; // next middle result
	sbau_res_t l2_r; // middle result register
	wire logic [SBAU_WORD_W-1:0] avg4_word; // both averages in even bytes

	assign avg4_word = (SBAU_WORD_W'(s1_hi_r) << SBAU_AVG4_HI_POS) | (SBAU_WORD_W'(s1_lo_r) << SBAU_AVG4_LO_POS);
	assign l2_nxt.valid = s1_sad_r || s1_avg4_r;
	assign l2_nxt.to_br = 1'b0;
	assign l2_nxt.br = '0;
	assign l2_nxt.data = s1_sad_r ? SBAU_WORD_W'(sad_sum) :
		s1_avg4_r ? avg4_word : '0;

	// middle stage register, two cycles from issue
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			l2_r <= SBAU_RES_RESET;
		end else begin
			l2_r <= l2_nxt;
		end
	end
	assign RES_L2 = l2_r;

	// long latency: products, pair sums, final sum
	logic m1_v_r; // products valid
	logic m2_v_r; // pair sums valid
	logic [SBAU_LANES-1:0][SBAU_PROD_W-1:0] m1_prod_r; // registered products
	logic signed [SBAU_PAIR_W-1:0] m2_lo_r; // lanes 0 and 1
	logic signed [SBAU_PAIR_W-1:0] m2_hi_r; // lanes 2 and 3
	wire logic signed [SBAU_PAIR_W-1:0] pair_lo; // next lower pair
	wire logic signed [SBAU_PAIR_W-1:0] pair_hi; // next upper pair
	wire logic signed [SBAU_MAC_W-1:0] mac_sum; // full sum

	assign pair_lo = SBAU_PAIR_W'($signed(m1_prod_r[0])) + SBAU_PAIR_W'($signed(m1_prod_r[1]));
	assign pair_hi = SBAU_PAIR_W'($signed(m1_prod_r[2])) + SBAU_PAIR_W'($signed(m1_prod_r[3]));
	assign mac_sum = SBAU_MAC_W'(m2_lo_r) + SBAU_MAC_W'(m2_hi_r);

	sbau_res_t l3_nxt; // next long result
	sbau_res_t l3_r; // long result register
	assign l3_nxt.valid = m2_v_r;
	assign l3_nxt.to_br = 1'b0;
	assign l3_nxt.br = '0;
	assign l3_nxt.data = m2_v_r ? SBAU_WORD_W'(mac_sum) : '0;

	// three-stage product pipeline
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			m1_v_r <= 1'b0;
			m2_v_r <= 1'b0;
			m1_prod_r <= '0;
			m2_lo_r <= '0;
			m2_hi_r <= '0;
			l3_r <= SBAU_RES_RESET;
		end else begin
			m1_v_r <= is_mac;
			m2_v_r <= m1_v_r;
			m1_prod_r <= prod;
			m2_lo_r <= pair_lo;
			m2_hi_r <= pair_hi;
			l3_r <= l3_nxt;
		end
	end
	assign RES_L3 = l3_r;

	// reference values seen only by the checks below
	logic signed [SBAU_MAC_W-1:0] ref_mac; // independent product sum
	logic [SBAU_SAD_W-1:0] ref_sad; // independent difference sum
	logic [SBAU_SUM4_W-1:0] ref_lo_sum; // lower four-byte sum
	logic [SBAU_SUM4_W-1:0] ref_hi_sum; // upper four-byte sum
	always_comb begin
		ref_mac = '0;
		ref_sad = '0;
		for (int k = 0; k < SBAU_LANES; k++) begin
			// factors widened before the multiply so no product bits are lost
			ref_mac = ref_mac + SBAU_MAC_W'($signed({1'b0, ISSUE.src1[k*8 +: 8]}))
				* SBAU_MAC_W'($signed(ISSUE.src2[k*8 +: 8]));
			// larger byte minus smaller, so the difference never wraps
			if (ISSUE.src1[k*8 +: 8] > ISSUE.src2[k*8 +: 8]) begin
				ref_sad = ref_sad + SBAU_SAD_W'(ISSUE.src1[k*8 +: 8]) - SBAU_SAD_W'(ISSUE.src2[k*8 +: 8]);
			end else begin
				ref_sad = ref_sad + SBAU_SAD_W'(ISSUE.src2[k*8 +: 8]) - SBAU_SAD_W'(ISSUE.src1[k*8 +: 8]);
			end
		end
	end
	assign ref_lo_sum = SBAU_SUM4_W'(ISSUE.src1[7:0]) + SBAU_SUM4_W'(ISSUE.src1[15:8])
		+ SBAU_SUM4_W'(ISSUE.src2[7:0]) + SBAU_SUM4_W'(ISSUE.src2[15:8]);
	assign ref_hi_sum = SBAU_SUM4_W'(ISSUE.src1[23:16]) + SBAU_SUM4_W'(ISSUE.src1[31:24])
		+ SBAU_SUM4_W'(ISSUE.src2[23:16]) + SBAU_SUM4_W'(ISSUE.src2[31:24]);

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);

	// issue of a given operation
	sequence s_abs;
		is_abs;
	endsequence
	sequence s_sad;
		is_sad;
	endsequence
	sequence s_mac;
		is_mac;
	endsequence
	sequence s_avg4;
		is_avg4;
	endsequence

	AST_ABS_LANE0: assert property (s_abs |=> RES_L1.valid && RES_L1.data[7:0] ==
		(($past(ISSUE.src1[7:0]) > $past(ISSUE.src2[7:0])) ? $past(ISSUE.src1[7:0]) - $past(ISSUE.src2[7:0])
		: $past(ISSUE.src2[7:0]) - $past(ISSUE.src1[7:0])))
		else $error("lane difference wrong");
	AST_SAD_LAT: assert property (s_sad |-> ##2 RES_L2.valid && RES_L2.data[31:10] == 22'h000000)
		else $error("summed difference late or not zero-extended");
	AST_AVG2_ZERO: assert property (is_avg2 && ISSUE.branch_condition_operand == 4'h0 |=>
		RES_L1.data[7:0] == 8'((9'($past(ISSUE.src1[7:0])) + 9'($past(ISSUE.src2[7:0]))) >> 1))
		else $error("two-way average truncation wrong");
	AST_AVG2_UP_LANE3: assert property (is_avg2 && ISSUE.branch_condition_operand != 4'h0 |=>
		RES_L1.data[31:24] == 8'((9'($past(ISSUE.src1[31:24])) + 9'($past(ISSUE.src2[31:24])) + 9'h001) >> 1))
		else $error("two-way average upward rounding wrong");
	AST_AVG4_LO: assert property (is_avg4 |-> ##2 RES_L2.valid && RES_L2.data[7:0] ==
		8'(($past(ref_lo_sum, 2) + 10'($past(rnd4_mode, 2))) >> 2))
		else $error("four-way average lower result wrong");
	AST_CMP_BR: assert property (is_eq && ISSUE.to_br |=> RES_L1.to_br && RES_L1.data == 32'h00000000
		&& RES_L1.br[0] == ($past(ISSUE.src1[7:0]) == $past(ISSUE.src2[7:0])))
		else $error("equality into branch register wrong");
	AST_CMP_GR: assert property (is_gt && !ISSUE.to_br |=> !RES_L1.to_br && RES_L1.data[15:9] == 7'h00
		&& RES_L1.data[8] == ($past(ISSUE.src1[15:8]) > $past(ISSUE.src2[15:8])))
		else $error("greater compare into general register wrong");
	AST_MAC_VALUE: assert property (s_mac |-> ##3 RES_L3.valid && $signed(RES_L3.data) == $past(ref_mac, 3))
		else $error("multiply add across wrong");
	AST_L3_SOURCE: assert property (RES_L3.valid |-> $past(is_mac, 3))
		else $error("long result without matching issue");
	AST_L2_SOURCE: assert property (RES_L2.valid |-> $past(is_sad || is_avg4, 2))
		else $error("middle result without matching issue");
	AST_L1_SOURCE: assert property (RES_L1.valid |-> $past(is_abs || is_avg2 || is_cmp))
		else $error("short result without matching issue");
	AST_SAD_VALUE: assert property (s_sad |-> ##2 RES_L2.data[9:0] == $past(ref_sad, 2))
		else $error("summed difference value wrong");
	AST_AVG4_HI: assert property (s_avg4 |-> ##2 RES_L2.valid && RES_L2.data[23:16] ==
		8'(($past(ref_hi_sum, 2) + 10'($past(rnd4_mode, 2))) >> 2))
		else $error("four-way average upper result wrong");
	AST_AVG4_FILL: assert property (s_avg4 |-> ##2 RES_L2.data[31:24] == 8'h00 && RES_L2.data[15:8] == 8'h00)
		else $error("four-way average odd bytes not cleared");
	AST_GT_BR_LANE3: assert property (is_gt && ISSUE.to_br |=> RES_L1.to_br
		&& RES_L1.br[3] == ($past(ISSUE.src1[31:24]) > $past(ISSUE.src2[31:24])))
		else $error("greater compare into branch register wrong");
	AST_EQ_GR_LANE2: assert property (is_eq && !ISSUE.to_br |=> !RES_L1.to_br && RES_L1.br == 4'h0
		&& RES_L1.data[23:16] == {7'h00, $past(ISSUE.src1[23:16]) == $past(ISSUE.src2[23:16])})
		else $error("equality into general register wrong");

endmodule : sbau_top

// file: tb/sbau_issue_model.sv
// issue pipeline stand-in: presents one operation per cycle to the unit
// assumes the bench calls drive once per cycle; inputs change at the falling edge
`timescale 1ns/1ps
module sbau_issue_model import sbau_pkg::*; (
	input wire logic CLK,
	output sbau_issue_t ISSUE
);
	// idle until the first call
	initial begin
		ISSUE = '0;
	end

	// wait for the falling edge, then present one operation for the next rising edge
	task automatic drive(input sbau_issue_t it);
		@(negedge CLK);
		ISSUE = it;
	endtask : drive
endmodule : sbau_issue_model

// file: tb/sbau_top_test.sv
// self-checking bench for the byte arithmetic unit, integer reference model with result queues
// assumes the issue model drives ISSUE; results are checked one ns after each falling edge
`timescale 1ns/1ps
module sbau_top_test;
	import sbau_pkg::*;
	localparam int LIMIT = 3000; // cycle ceiling for a hang
	logic CLK = 1'b0; // core clock, low from the start so no edge at time zero
	logic RESETN; // async reset, active low
	sbau_issue_t ISSUE; // from the issue model
	sbau_res_t RES_L1, RES_L2, RES_L3; // result ports
	sbau_res_t got [3]; // sampled ports
	sbau_res_t exp_q [3][$]; // expected results per port
	int due_q [3][$]; // cycle each result is due
	int n_mismatch = 0; // mismatches
	int comparisons = 0; // compares made
	int cyc = 0; // rising edges seen
	sbau_issue_t it; // stimulus word

	sbau_issue_model u_model (.CLK(CLK), .ISSUE(ISSUE));
	sbau_top dut_u (.CLK(CLK), .RESETN(RESETN), .ISSUE(ISSUE), .RES_L1(RES_L1), .RES_L2(RES_L2), .RES_L3(RES_L3));

	// 250 MHz clock
	initial begin
		CLK = 1'b0;
		forever #2 CLK = ~CLK;
	end

	// edge counter and hang guard
	always @(posedge CLK) begin
		cyc++;
		if (cyc == LIMIT) begin
			n_mismatch++;
			finish_test();
		end
	end

	// result port of an operation, -1 when none
	function automatic int port_of(input sbau_issue_t x);
		case (x.op)
			SBAU_LANE_ABS_DIFF, SBAU_LANE_ABS_DIFF_ALIAS, SBAU_TWO_WAY_AVERAGE: return 0;
			SBAU_BYTE_EQUAL_COMPARE, SBAU_BYTE_UNSIGNED_GREATER_COMPARE: return 0;
			SBAU_SUMMED_ABS_DIFF, SBAU_FOUR_WAY_AVERAGE: return 1;
			SBAU_MIXED_SIGN_MULTIPLY_ADD_ACROSS: return 2;
			default: return -1; // no result
		endcase
	endfunction : port_of

	// reference result from the rules, integer arithmetic
	function automatic sbau_res_t model(input sbau_issue_t x);
		sbau_res_t r;
		int s, lo, hi;
		logic [7:0] a, b;
		logic tr;
		r = '0;
		r.valid = 1'b1;
		s = 0;
		lo = 0;
		hi = 0;
		for (int i = 0; i < 4; i++) begin
			a = x.src1[8*i +: 8]; // unsigned bytes
			b = x.src2[8*i +: 8];
			case (x.op)
				SBAU_LANE_ABS_DIFF, SBAU_LANE_ABS_DIFF_ALIAS: r.data[8*i +: 8] = (a > b) ? a - b : b - a;
				SBAU_SUMMED_ABS_DIFF: s += (a > b) ? a - b : b - a;
				SBAU_TWO_WAY_AVERAGE: r.data[8*i +: 8] = 8'((int'(a) + int'(b) + int'(x.branch_condition_operand != 4'h0)) >> 1);
				SBAU_FOUR_WAY_AVERAGE: if (i < 2) lo += int'(a) + int'(b); else hi += int'(a) + int'(b);
				SBAU_MIXED_SIGN_MULTIPLY_ADD_ACROSS: s += int'(a) * int'($signed(b));
				default: begin
					tr = (x.op == SBAU_BYTE_EQUAL_COMPARE) ? (a == b) : (a > b);
					if (x.to_br) r.br[i] = tr;
					else r.data[8*i] = tr;
				end
			endcase
		end
		if (x.op == SBAU_SUMMED_ABS_DIFF || x.op == SBAU_MIXED_SIGN_MULTIPLY_ADD_ACROSS) r.data = 32'(s);
		if (x.op == SBAU_FOUR_WAY_AVERAGE) begin
			r.data[7:0] = 8'((lo + int'(x.branch_condition_operand[1:0])) >> 2);
			r.data[23:16] = 8'((hi + int'(x.branch_condition_operand[1:0])) >> 2);
		end
		if (x.op == SBAU_BYTE_EQUAL_COMPARE || x.op == SBAU_BYTE_UNSIGNED_GREATER_COMPARE) r.to_br = x.to_br;
		return r;
	endfunction : model

	// issue one operation and queue its expected result at its fixed latency
	task automatic issue(input sbau_issue_t x);
		int p;
		p = port_of(x);
		u_model.drive(x);
		if (x.valid && p >= 0) begin
			exp_q[p].push_back(model(x));
			due_q[p].push_back(cyc + SBAU_LAT_SHORT + p);
		end
	endtask : issue

	// random operation, fields within the issue word, illegal codes included
	task automatic rand_issue();
		it.valid = ($urandom % 4) != 0;
		it.op = sbau_op_t'(4'($urandom));
		it.to_br = 1'($urandom);
		it.branch_condition_operand = 4'($urandom);
		it.src1 = $urandom;
		it.src2 = $urandom;
		issue(it);
	endtask : rand_issue

	// compare every port once a cycle, settled after the falling edge
	always @(negedge CLK) begin
		#1;
		got[0] = RES_L1;
		got[1] = RES_L2;
		got[2] = RES_L3;
		for (int p = 0; p < 3; p++) begin
			comparisons++;
			if (!RESETN) begin
				if (got[p] !== SBAU_RES_RESET) begin
					n_mismatch++;
					$display("[FAIL] %0t port %0d not cleared in reset", $time, p);
				end
			end else if (due_q[p].size() > 0 && due_q[p][0] == cyc) begin
				void'(due_q[p].pop_front());
				if (got[p] !== exp_q[p][0]) begin
					n_mismatch++;
					$display("[FAIL] %0t port %0d got %h exp %h", $time, p, got[p], exp_q[p][0]);
				end
				void'(exp_q[p].pop_front());
			end else if (got[p] !== SBAU_RES_RESET) begin
				n_mismatch++;
				$display("[FAIL] %0t port %0d result without operation", $time, p);
			end
		end
	end

	// reset for two cycles, dropping whatever was in flight
	task automatic do_reset();
		@(negedge CLK);
		RESETN = 1'b0;
		for (int p = 0; p < 3; p++) begin
			exp_q[p].delete();
			due_q[p].delete();
		end
		u_model.drive('0);
		@(negedge CLK);
		RESETN = 1'b1;
	endtask : do_reset

	// print counts and verdict, then stop
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : finish_test

	// main sequence
	initial begin
		RESETN = 1'b0;
		void'($urandom(32'hA05A));
		repeat (2) @(negedge CLK);
		RESETN = 1'b1;
		// boundary bytes, every operation, every rounding code, both compare targets
		for (int op = 1; op <= 8; op++) begin
			for (int k = 0; k < 10; k++) begin
				it.valid = 1'b1;
				it.op = sbau_op_t'(4'(op));
				it.to_br = 1'(k);
				it.branch_condition_operand = (k < 8) ? 4'(k / 2) : 4'h8;
				it.src1 = 32'hFF01_7F81;
				it.src2 = 32'h00FE_8080;
				issue(it);
			end
		end
		// back to back random traffic
		repeat (600) rand_issue();
		// reset with results in flight, then traffic again
		do_reset();
		repeat (100) rand_issue();
		u_model.drive('0);
		repeat (6) @(negedge CLK);
		// every queued result must have been seen by now
		for (int p = 0; p < 3; p++) begin
			if (exp_q[p].size() != 0) begin
				n_mismatch++;
				$display("[FAIL] %0t port %0d results never seen", $time, p);
			end
		end
		finish_test();
	end
endmodule : sbau_top_test
